/* File: src/sac_amp_ctrl.sv */
// Per-amplifier decode of control and trim settings into analog outputs
`timescale 1ns/100ps
module sac_amp_ctrl (
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       rstn_in,
    // Next register values and filtered comparator level
    input  wire logic [7:0] ctrl_nxt_in,
    input  wire logic [7:0] trim_nxt_in,
    input  wire logic       amp_level_in,
    // Analog controls and gated comparator status
    output logic            enable_out,
    output logic [1:0]      bandwidth_out,
    output logic            cal_mode_out,
    output logic            cal_ref_sel_out,
    output logic [5:0]      trim_out,
    output logic            cal_close_out,
    output logic            status_out
);

    // Built from next values so the analog side follows a write at once
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            enable_out      <= 1'b0;
            bandwidth_out   <= sac_pkg::SAC_BW_5K;
            cal_mode_out    <= 1'b0;
            cal_ref_sel_out <= 1'b0;
            trim_out        <= sac_pkg::TRIM_RST[5:0];
            cal_close_out   <= 1'b0;
        end else begin
            enable_out      <= ctrl_nxt_in[sac_pkg::EN_BIT];
            bandwidth_out   <= ctrl_nxt_in[1:0];
            cal_mode_out    <= trim_nxt_in[sac_pkg::CAL_BIT];
            cal_ref_sel_out <= trim_nxt_in[sac_pkg::REF_BIT];
            trim_out        <= trim_nxt_in[5:0];
            cal_close_out   <= trim_nxt_in[sac_pkg::CAL_BIT] & trim_nxt_in[sac_pkg::REF_BIT];
        end
    end

    // Status forced low outside calibration
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            status_out <= 1'b0;
        end else begin
            status_out <= trim_nxt_in[sac_pkg::CAL_BIT] & amp_level_in;
        end
    end

endmodule : sac_amp_ctrl

/* File: src/sac_pkg.sv */
// Shared constants and types of the smoke front-end control register bank
package sac_pkg;

    // ******************************************************************
    // Bus geometry
    // ******************************************************************
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int AMP_N  = 2;

    // ******************************************************************
    // Register offsets
    // ******************************************************************
    localparam logic [2:0] SWITCH_OFS    = 3'h0;
    localparam logic [2:0] GAIN0_OFS     = 3'h1;
    localparam logic [2:0] GAIN1_OFS     = 3'h2;
    localparam logic [2:0] AMP0_CTRL_OFS = 3'h3;
    localparam logic [2:0] AMP1_CTRL_OFS = 3'h4;
    localparam logic [2:0] AMP0_TRIM_OFS = 3'h5;
    localparam logic [2:0] AMP1_TRIM_OFS = 3'h6;

    // ******************************************************************
    // Values after reset
    // ******************************************************************
    localparam logic [7:0] SWITCH_RST = 8'h00;
    localparam logic [7:0] GAIN0_RST  = 8'h00;
    localparam logic [7:0] GAIN1_RST  = 8'h00;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] TRIM_RST   = 8'h20;

    // ******************************************************************
    // Writable bit masks
    // ******************************************************************
    localparam logic [7:0] SWITCH_MASK = 8'h7F;
    localparam logic [7:0] GAIN0_MASK  = 8'h3F;
    localparam logic [7:0] GAIN1_MASK  = 8'hFF;
    localparam logic [7:0] CTRL_MASK   = 8'h43;
    localparam logic [7:0] TRIM_MASK   = 8'hFF;

    // ******************************************************************
    // Field positions
    // ******************************************************************
    localparam int CPL_MSB  = 6;
    localparam int CPL_LSB  = 5;
    localparam int EN_BIT   = 6;
    localparam int STAT_BIT = 5;
    localparam int CAL_BIT  = 7;
    localparam int REF_BIT  = 6;
    localparam int R3_MSB   = 7;
    localparam int R3_LSB   = 6;

    // ******************************************************************
    // Resistance steps and synchroniser depth
    // ******************************************************************
    localparam logic [12:0] R_STEP_KOHM  = 13'h0064;
    localparam logic [5:0]  R3_STEP_KOHM = 6'h0A;
    localparam int          SYNC_STAGES  = 3;

    // ******************************************************************
    // Encodings
    // ******************************************************************
    typedef enum logic [1:0] {
        SAC_CPL_EXT_A = 2'b00,
        SAC_CPL_AC    = 2'b01,
        SAC_CPL_EXT_B = 2'b10,
        SAC_CPL_DC    = 2'b11
    } sac_coupling_t;

    typedef enum logic [1:0] {
        SAC_BW_5K   = 2'b00,
        SAC_BW_40K  = 2'b01,
        SAC_BW_600K = 2'b10,
        SAC_BW_2M   = 2'b11
    } sac_bandwidth_t;

endpackage : sac_pkg

/* File: src/sac_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module sac_sync (
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic rstn_in,
    // Raw and filtered level
    input  wire logic async_in,
    output logic      level_out
);

    logic [sac_pkg::SYNC_STAGES-1:0] stage_r;
    logic                            level_r;

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stage_r <= '0;
        end else begin
            stage_r <= {stage_r[sac_pkg::SYNC_STAGES-2:0], async_in};
        end
    end

    // Stage 0 is only read by stage 1; a change counts once 1 and 2 agree
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            level_r <= 1'b0;
        end else if (stage_r[1] == stage_r[2]) begin
            level_r <= stage_r[2];
        end
    end

    assign level_out = level_r;

endmodule : sac_sync

/* File: src/smoke_afe_control_regs.sv */
// Control and status register bank of the two-amplifier smoke front end
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/100ps
module smoke_afe_control_regs (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        rstn_in,
    // Register port
    input  wire logic [2:0]  addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [7:0]  rdata_out,
    // Amplifier comparator levels
    input  wire logic        amp0_status_in,
    input  wire logic        amp1_status_in,
    // Coupling mode
    output logic             ext_mode_out,
    output logic             ac_coupling_out,
    output logic             dc_coupling_out,
    // Front-end switches
    output logic             front_switch_a_out,
    output logic             front_switch_b_out,
    output logic             front_switch_c_out,
    output logic             front_switch_d_out,
    output logic             front_switch_e_out,
    // Gain resistor networks
    output logic      [5:0]  first_gain_code_out,
    output logic      [12:0] first_res_kohm_out,
    output logic      [5:0]  second_gain_code_out,
    output logic      [12:0] second_res_kohm_out,
    output logic      [5:0]  third_res_kohm_out,
    // Amplifier 0 controls
    output logic             amp0_enable_out,
    output logic      [1:0]  amp0_bandwidth_out,
    output logic             amp0_cal_mode_out,
    output logic             amp0_cal_ref_sel_out,
    output logic      [5:0]  amp0_trim_out,
    // Amplifier 1 controls
    output logic             amp1_enable_out,
    output logic      [1:0]  amp1_bandwidth_out,
    output logic             amp1_cal_mode_out,
    output logic             amp1_cal_ref_sel_out,
    output logic      [5:0]  amp1_trim_out
);

    // ******************************************************************
    // Register storage
    // ******************************************************************
    logic [7:0] switch_r;
    logic [7:0] switch_nxt;
    logic [7:0] gain0_r;
    logic [7:0] gain0_nxt;
    logic [7:0] gain1_r;
    logic [7:0] gain1_nxt;
    logic [7:0] ctrl_r     [sac_pkg::AMP_N];
    logic [7:0] ctrl_nxt   [sac_pkg::AMP_N];
    logic [7:0] trim_r     [sac_pkg::AMP_N];
    logic [7:0] trim_nxt   [sac_pkg::AMP_N];
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // ******************************************************************
    // Per-amplifier signals
    // ******************************************************************
    logic [sac_pkg::AMP_N-1:0] amp_raw;
    logic [sac_pkg::AMP_N-1:0] amp_level;
    logic [sac_pkg::AMP_N-1:0] amp_enable;
    logic [1:0]                amp_bw       [sac_pkg::AMP_N];
    logic [sac_pkg::AMP_N-1:0] amp_cal;
    logic [sac_pkg::AMP_N-1:0] amp_ref;
    logic [5:0]                amp_trim     [sac_pkg::AMP_N];
    logic [sac_pkg::AMP_N-1:0] amp_status;
    logic [sac_pkg::AMP_N-1:0] amp_close_nxt;

    // ******************************************************************
    // Output flops of the shared controls
    // ******************************************************************
    logic        ext_mode_r;
    logic        ac_coupling_r;
    logic        dc_coupling_r;
    logic [4:0]  switch_out_r;
    logic [5:0]  first_code_r;
    logic [12:0] first_res_r;
    logic [5:0]  second_code_r;
    logic [12:0] second_res_r;
    logic [5:0]  third_res_r;

    assign amp_raw = {amp1_status_in, amp0_status_in};

    // ******************************************************************
    // Write decode
    // ******************************************************************
    // Masked writes keep unimplemented and read-only bits at zero
    always_comb begin
        switch_nxt = switch_r;
        gain0_nxt  = gain0_r;
        gain1_nxt  = gain1_r;
        if (wr_in && addr_in == sac_pkg::SWITCH_OFS) begin
            switch_nxt = wdata_in & sac_pkg::SWITCH_MASK;
        end
        if (wr_in && addr_in == sac_pkg::GAIN0_OFS) begin
            gain0_nxt = wdata_in & sac_pkg::GAIN0_MASK;
        end
        if (wr_in && addr_in == sac_pkg::GAIN1_OFS) begin
            gain1_nxt = wdata_in & sac_pkg::GAIN1_MASK;
        end
    end

    always_comb begin
        ctrl_nxt[0] = ctrl_r[0];
        ctrl_nxt[1] = ctrl_r[1];
        trim_nxt[0] = trim_r[0];
        trim_nxt[1] = trim_r[1];
        if (wr_in && addr_in == sac_pkg::AMP0_CTRL_OFS) begin
            ctrl_nxt[0] = wdata_in & sac_pkg::CTRL_MASK;
        end
        if (wr_in && addr_in == sac_pkg::AMP1_CTRL_OFS) begin
            ctrl_nxt[1] = wdata_in & sac_pkg::CTRL_MASK;
        end
        if (wr_in && addr_in == sac_pkg::AMP0_TRIM_OFS) begin
            trim_nxt[0] = wdata_in & sac_pkg::TRIM_MASK;
        end
        if (wr_in && addr_in == sac_pkg::AMP1_TRIM_OFS) begin
            trim_nxt[1] = wdata_in & sac_pkg::TRIM_MASK;
        end
    end

    // ******************************************************************
    // Registers
    // ******************************************************************
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            switch_r <= sac_pkg::SWITCH_RST;
        end else begin
            switch_r <= switch_nxt;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            gain0_r <= sac_pkg::GAIN0_RST;
            gain1_r <= sac_pkg::GAIN1_RST;
        end else begin
            gain0_r <= gain0_nxt;
            gain1_r <= gain1_nxt;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_r[0] <= sac_pkg::CTRL_RST;
            ctrl_r[1] <= sac_pkg::CTRL_RST;
        end else begin
            ctrl_r[0] <= ctrl_nxt[0];
            ctrl_r[1] <= ctrl_nxt[1];
        end
    end

    // Trim midpoint after reset so an uncalibrated amplifier sits centred
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            trim_r[0] <= sac_pkg::TRIM_RST;
            trim_r[1] <= sac_pkg::TRIM_RST;
        end else begin
            trim_r[0] <= trim_nxt[0];
            trim_r[1] <= trim_nxt[1];
        end
    end

    // ******************************************************************
    // Per-amplifier channels
    // ******************************************************************
    for (genvar gi = 0; gi < sac_pkg::AMP_N; gi++) begin : g_amp
        sac_sync u_sync (
            .clock_in  (clock_in),
            .rstn_in   (rstn_in),
            .async_in  (amp_raw[gi]),
            .level_out (amp_level[gi])
        );

        sac_amp_ctrl u_ctrl (
            .clock_in        (clock_in),
            .rstn_in         (rstn_in),
            .ctrl_nxt_in     (ctrl_nxt[gi]),
            .trim_nxt_in     (trim_nxt[gi]),
            .amp_level_in    (amp_level[gi]),
            .enable_out      (amp_enable[gi]),
            .bandwidth_out   (amp_bw[gi]),
            .cal_mode_out    (amp_cal[gi]),
            .cal_ref_sel_out (amp_ref[gi]),
            .trim_out        (amp_trim[gi]),
            // Closure is taken from next values below, so this copy is unused
            .cal_close_out   (),
            .status_out      (amp_status[gi])
        );

        assign amp_close_nxt[gi] = trim_nxt[gi][sac_pkg::CAL_BIT] & trim_nxt[gi][sac_pkg::REF_BIT];
    end

    // ******************************************************************
    // Coupling mode and switches
    // ******************************************************************
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ext_mode_r    <= 1'b1;
            ac_coupling_r <= 1'b0;
            dc_coupling_r <= 1'b0;
        end else begin
            case (sac_pkg::sac_coupling_t'(switch_nxt[sac_pkg::CPL_MSB:sac_pkg::CPL_LSB]))
                sac_pkg::SAC_CPL_AC: begin
                    ext_mode_r    <= 1'b0;
                    ac_coupling_r <= 1'b1;
                    dc_coupling_r <= 1'b0;
                end
                sac_pkg::SAC_CPL_DC: begin
                    ext_mode_r    <= 1'b0;
                    ac_coupling_r <= 1'b0;
                    dc_coupling_r <= 1'b1;
                end
                default: begin
                    ext_mode_r    <= 1'b1;
                    ac_coupling_r <= 1'b0;
                    dc_coupling_r <= 1'b0;
                end
            endcase
        end
    end

    // Calibration with reference select overrides switches a and c closed; b is not guarded
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            switch_out_r <= 5'h00;
        end else begin
            switch_out_r[0] <= switch_nxt[0] | (|amp_close_nxt);
            switch_out_r[1] <= switch_nxt[1];
            switch_out_r[2] <= switch_nxt[2] | (|amp_close_nxt);
            switch_out_r[3] <= switch_nxt[3];
            switch_out_r[4] <= switch_nxt[4];
        end
    end

    // ******************************************************************
    // Gain resistor networks
    // ******************************************************************
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            first_code_r  <= 6'h00;
            first_res_r   <= 13'h0000;
            second_code_r <= 6'h00;
            second_res_r  <= 13'h0000;
            third_res_r   <= sac_pkg::R3_STEP_KOHM;
        end else begin
            first_code_r  <= gain0_nxt[5:0];
            first_res_r   <= 13'({7'h00, gain0_nxt[5:0]} * sac_pkg::R_STEP_KOHM);
            second_code_r <= gain1_nxt[5:0];
            second_res_r  <= 13'({7'h00, gain1_nxt[5:0]} * sac_pkg::R_STEP_KOHM);
            third_res_r   <= 6'(({4'h0, gain1_nxt[sac_pkg::R3_MSB:sac_pkg::R3_LSB]} + 6'h01)
                                * sac_pkg::R3_STEP_KOHM);
        end
    end

    // ******************************************************************
    // Read path
    // ******************************************************************
    // Status is inserted at read time; stored bit 5 of control is always zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (rd_in) begin
            case (addr_in)
                sac_pkg::SWITCH_OFS:    rdata_nxt = switch_r;
                sac_pkg::GAIN0_OFS:     rdata_nxt = gain0_r;
                sac_pkg::GAIN1_OFS:     rdata_nxt = gain1_r;
                sac_pkg::AMP0_CTRL_OFS: rdata_nxt = ctrl_r[0] | {2'b00, amp_status[0], 5'h00};
                sac_pkg::AMP1_CTRL_OFS: rdata_nxt = ctrl_r[1] | {2'b00, amp_status[1], 5'h00};
                sac_pkg::AMP0_TRIM_OFS: rdata_nxt = trim_r[0];
                sac_pkg::AMP1_TRIM_OFS: rdata_nxt = trim_r[1];
                default:                rdata_nxt = 8'h00;
            endcase
        end
    end

    // Read data hold only in the cycle after the strobe
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ******************************************************************
    // Output assignment
    // ******************************************************************
    assign rdata_out            = rdata_r;
    assign ext_mode_out         = ext_mode_r;
    assign ac_coupling_out      = ac_coupling_r;
    assign dc_coupling_out      = dc_coupling_r;
    assign front_switch_a_out   = switch_out_r[0];
    assign front_switch_b_out   = switch_out_r[1];
    assign front_switch_c_out   = switch_out_r[2];
    assign front_switch_d_out   = switch_out_r[3];
    assign front_switch_e_out   = switch_out_r[4];
    assign first_gain_code_out  = first_code_r;
    assign first_res_kohm_out   = first_res_r;
    assign second_gain_code_out = second_code_r;
    assign second_res_kohm_out  = second_res_r;
    assign third_res_kohm_out   = third_res_r;
    assign amp0_enable_out      = amp_enable[0];
    assign amp0_bandwidth_out   = amp_bw[0];
    assign amp0_cal_mode_out    = amp_cal[0];
    assign amp0_cal_ref_sel_out = amp_ref[0];
    assign amp0_trim_out        = amp_trim[0];
    assign amp1_enable_out      = amp_enable[1];
    assign amp1_bandwidth_out   = amp_bw[1];
    assign amp1_cal_mode_out    = amp_cal[1];
    assign amp1_cal_ref_sel_out = amp_ref[1];
    assign amp1_trim_out        = amp_trim[1];

endmodule : smoke_afe_control_regs

/* File: testbench/sac_regs_props.sv */
// Port checks of the smoke front-end register bank
`timescale 1ns/100ps
module sac_regs_props (
    // Clock, reset and register port
    input wire logic        clock_in, rstn_in, wr_in, rd_in,
    input wire logic [2:0]  addr_in,
    input wire logic [7:0]  wdata_in, rdata_out,
    // Decoded controls
    input wire logic        ext_mode_out, dc_coupling_out, front_switch_a_out, front_switch_c_out,
    input wire logic        front_switch_d_out, amp0_enable_out, amp0_cal_mode_out, amp0_cal_ref_sel_out,
    input wire logic [5:0]  first_gain_code_out, third_res_kohm_out, amp0_trim_out,
    input wire logic [12:0] first_res_kohm_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    // ****************
    // Assertions
    // ****************
    chk_coupling_dc: assert property (wr_in && addr_in == 3'h0 |=> dc_coupling_out == &$past(wdata_in[6:5]))
        else $error("dc decode wrong");
    chk_coupling_ext: assert property (wr_in && addr_in == 3'h0 |=> ext_mode_out == !$past(wdata_in[5]))
        else $error("ext decode wrong");
    chk_switch_d: assert property (wr_in && addr_in == 3'h0 |=> front_switch_d_out == $past(wdata_in[3]))
        else $error("switch d wrong");
    chk_first_res: assert property (first_res_kohm_out == 13'(first_gain_code_out) * 13'h0064)
        else $error("first resistance wrong");
    chk_third_res: assert property (wr_in && addr_in == 3'h2 |=> third_res_kohm_out == 6'h0A * ($past(wdata_in[7:6]) + 6'h01))
        else $error("third resistance wrong");
    chk_amp_enable: assert property (wr_in && addr_in == 3'h3 |=> amp0_enable_out == $past(wdata_in[6]))
        else $error("enable wrong");
    chk_status_gate: assert property (rd_in && addr_in == 3'h3 && !amp0_cal_mode_out |=> !rdata_out[5])
        else $error("status not gated");
    chk_cal_close: assert property (amp0_cal_mode_out && amp0_cal_ref_sel_out |-> front_switch_a_out && front_switch_c_out)
        else $error("cal switches open");
    chk_trim_write: assert property (wr_in && addr_in == 3'h5 |=> amp0_trim_out == $past(wdata_in[5:0]))
        else $error("trim not updated");
    chk_unmapped_read: assert property (rd_in && addr_in == 3'h7 |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    cover property (rd_in && addr_in == 3'h3 && amp0_cal_mode_out ##1 rdata_out[5]);
    cover property (dc_coupling_out);
    cover property (rd_in && addr_in == 3'h7);
endmodule : sac_regs_props

/* File: testbench/smoke_afe_control_regs_tb_top.sv */
// Self-checking bench of the smoke front-end register bank
`timescale 1ns/100ps
module smoke_afe_control_regs_tb_top;
    logic        clock_in, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
    logic        amp0_status_in = 1'b0, amp1_status_in = 1'b0;
    logic [2:0]  addr_in = 3'h0;
    logic [7:0]  wdata_in = 8'h00, rdata_out;
    logic        ext_mode_out, ac_coupling_out, dc_coupling_out, front_switch_a_out, front_switch_b_out;
    logic        front_switch_c_out, front_switch_d_out, front_switch_e_out;
    logic [5:0]  first_gain_code_out, second_gain_code_out, third_res_kohm_out, amp0_trim_out, amp1_trim_out;
    logic [12:0] first_res_kohm_out, second_res_kohm_out;
    logic        amp0_enable_out, amp0_cal_mode_out, amp0_cal_ref_sel_out;
    logic        amp1_enable_out, amp1_cal_mode_out, amp1_cal_ref_sel_out;
    logic [1:0]  amp0_bandwidth_out, amp1_bandwidth_out;
    int          err_total = 0, num_checks = 0;
    localparam logic [5:0] TH = 6'h17;

    smoke_afe_control_regs dut (.*);

    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    // Comparator stand-in: trips once trim reaches TH
    always @(posedge clock_in) amp0_status_in <= (amp0_trim_out >= TH);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h want=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clock_in);
        wr_in    <= 1'b0;
        @(negedge clock_in);
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clock_in);
        rd_in   <= 1'b0;
        @(negedge clock_in);
        d = rdata_out;
    endtask : rd_reg

    task automatic do_reset;
        @(posedge clock_in);
        rstn_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        rstn_in <= 1'b1;
    endtask : do_reset

    task automatic t_regs(input logic [63:0] exp);
        logic [7:0] r;
        for (int a = 0; a < 8; a++) begin
            rd_reg(3'(a), r);
            check(r, exp[a*8 +: 8]);
        end
    endtask : t_regs

    task automatic t_decode;
        logic [4:0] sw;
        logic [7:0] r;
        for (int c = 0; c < 4; c++) begin
            sw = c[1] ? 5'h15 : 5'h0A;
            wr_reg(3'h0, {1'b0, 2'(c), sw});
            check({ext_mode_out, ac_coupling_out, dc_coupling_out}, c == 1 ? 3'b010 : c == 3 ? 3'b001 : 3'b100);
            check({front_switch_e_out, front_switch_d_out, front_switch_c_out, front_switch_b_out, front_switch_a_out}, sw);
            wr_reg(3'h2, {2'(c), 6'h29});
            check({third_res_kohm_out, second_res_kohm_out, second_gain_code_out},
                  {6'(10 * (c + 1)), 13'h1004, 6'h29});
            wr_reg(3'h4, {6'h10, 2'(c)});
            wr_reg(3'h3, {6'h00, 2'(3 - c)});
            check({amp1_enable_out, amp1_bandwidth_out, amp0_enable_out, amp0_bandwidth_out},
                  {1'b1, 2'(c), 1'b0, 2'(3 - c)});
        end
        wr_reg(3'h1, 8'hEA);
        check({first_res_kohm_out, first_gain_code_out}, {13'h1068, 6'h2A});
        wr_reg(3'h6, 8'h9C);
        @(posedge clock_in);
        amp1_status_in <= 1'b1;
        repeat (8) @(posedge clock_in);
        rd_reg(3'h4, r);
        check({amp1_cal_mode_out, amp1_cal_ref_sel_out, amp1_trim_out, r}, {2'b10, 6'h1C, 8'h63});
    endtask : t_decode

    task automatic step(input logic [5:0] t, output logic s);
        logic [7:0] r;
        wr_reg(3'h5, {2'b11, t});
        repeat (8) @(posedge clock_in);
        rd_reg(3'h3, r);
        s = r[5];
    endtask : step

    task automatic t_cal;
        logic [5:0] lo, hi;
        logic       s0, s;
        step(6'h00, s0);
        check({front_switch_a_out, front_switch_c_out, amp0_cal_mode_out}, 3'b111);
        lo = 6'h00;
        do begin lo++; step(lo, s); end while (s === s0 && lo != 6'h3F);
        step(6'h3F, s0);
        hi = 6'h3F;
        do begin hi--; step(hi, s); end while (s === s0 && hi != 6'h00);
        check({lo, hi}, {TH, TH - 6'h01});
        wr_reg(3'h5, {2'b01, 6'((7'(lo) + 7'(hi)) >> 1)});
        check({amp0_cal_mode_out, amp0_cal_ref_sel_out, amp0_trim_out}, {2'b01, TH - 6'h01});
    endtask : t_cal

    task automatic end_sim;
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    initial begin
        do_reset();
        t_regs(64'h0020_2000_0000_0000);
        for (int a = 0; a < 8; a++) wr_reg(3'(a), a == 0 ? 8'hDF : 8'hFF);
        t_regs(64'h00FF_FF43_63FF_3F5F);
        do_reset();
        t_decode();
        t_cal();
        end_sim();
    end
endmodule : smoke_afe_control_regs_tb_top

bind smoke_afe_control_regs sac_regs_props u_props (.*);
